// ===== logic/dlc_control.v
// Data-link controller two: report fields, abort generation, receive check and discard
//
// Contract
// - First flag of each network report carries control bit 7.
// - Second flag of each network report carries control bit 6.
// - First spare bit of each supplementary report carries bit 5.
// - Second spare bit of each supplementary report carries bit 4.
// - Reserved bits of supplementary report come from bits 3..0, reset zero.
// - Carrier enable clear: plain superframe bits, no carrier-format messages.
// - Carrier enable set: carrier-format messages sent and received.
// - Carrier enable honoured only in carrier or extended superframe format.
// - Auto abort sends zero then seven ones on message-to-bit switch.
// - Bit 6 zero enables auto abort; one suppresses it.
// - Receive frame check verified while bit 5 zero, skipped when one.
// - Bit 4 set discards received frames identical to buffered content.
// - Bit 3 set sends continuous ones as abort; clear is normal.
// - Bit 0 picks bit-oriented (0) or message-oriented (1) send.
`timescale 1ns/1ns
`include "dlc_defines.vh"
module dlc_control (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Register port
    input wire [`DLC_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Framing format from the framer core
    input wire [1:0] frame_format,
    // Transmit side
    input wire tx_bit_en,
    input wire tx_msg_bit,
    output reg tx_dl_bit,
    output reg tx_abort_active,
    output wire tx_mos_select,
    output wire tx_carrier_active,
    output wire tx_sf_bits,
    output wire [7:0] tx_network_performance_report_fields,
    output wire [7:0] tx_supplementary_performance_report_fields,
    // Receive side, bytes of one frame from the deframer
    input wire rx_byte_valid,
    input wire [7:0] rx_byte,
    input wire rx_frame_end,
    input wire rx_carrier_msg,
    // Received byte stream to the user
    output wire rx_out_valid,
    input wire rx_out_ready,
    output wire [7:0] rx_out_data,
    output wire rx_byte_ready
);
    reg [7:0] prctl_q;
    reg [7:0] dlctl_q;
    reg sel_prev_q;
    reg [3:0] abort_cnt_q;
    reg [7:0] abort_sh_q;
    reg [15:0] fcs_q;
    reg [7:0] cur_buf [0:`DLC_RXBUF_DEPTH-1];
    reg [7:0] ref_buf [0:`DLC_RXBUF_DEPTH-1];
    reg [`DLC_RXBUF_AW:0] cur_len_q;
    reg [`DLC_RXBUF_AW:0] ref_len_q;
    reg [`DLC_RXBUF_AW:0] push_idx_q;
    reg [`DLC_RXBUF_AW:0] push_len_q;
    reg match_q;
    reg pushing_q;
    reg fcs_err_q;
    reg dup_q;
    reg good_q;
    reg [7:0] frames_q;
    wire fmt_ok;
    wire carrier_on;
    wire dup_now;
    wire fcs_ok;
    wire fifo_in_ready;
    wire rx_take;
    integer i;

    // One byte through the reflected frame check generator
    function [15:0] fcs_byte;
        input [15:0] crc;
        input [7:0] data;
        integer k;
        reg [15:0] c;
        begin
            c = crc ^ {8'h00, data};
            for (k = 0; k < 8; k = k + 1) begin
                c = c[0] ? ((c >> 1) ^ `DLC_FCS_POLY) : (c >> 1);
            end
            fcs_byte = c;
        end
    endfunction

    // Register writes and reads
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prctl_q <= `DLC_PRCTL_RST;
            dlctl_q <= `DLC_DLCTL_RST;
            reg_rdata <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == `DLC_ADDR_PRCTL) begin
                prctl_q <= reg_wdata;
            end
            if (reg_wr && reg_addr == `DLC_ADDR_DLCTL) begin
                dlctl_q <= reg_wdata;
            end
            if (reg_rd) begin
                case (reg_addr)
                    `DLC_ADDR_PRCTL: reg_rdata <= prctl_q;
                    `DLC_ADDR_DLCTL: reg_rdata <= dlctl_q;
                    `DLC_ADDR_STAT: reg_rdata <= {3'h0, pushing_q, good_q, dup_q, fcs_err_q, tx_abort_active};
                    `DLC_ADDR_RXDATA: reg_rdata <= frames_q;
                    default: reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // Report field images for the report builder
    assign tx_network_performance_report_fields = {prctl_q[`DLC_PR_FIRST_FLAG],
                             prctl_q[`DLC_PR_SECOND_FLAG],
                             6'h00};
    assign tx_supplementary_performance_report_fields = {2'h0,
                             prctl_q[`DLC_PR_SPARE_ONE],
                             prctl_q[`DLC_PR_SPARE_TWO],
                             prctl_q[3:0]};

    // Carrier format qualified by framing format
    assign fmt_ok = (frame_format == `DLC_FMT_CARRIER) || (frame_format == `DLC_FMT_ESF);
    assign carrier_on = dlctl_q[`DLC_DL_CARRIER_EN] & fmt_ok;
    assign tx_carrier_active = carrier_on;
    assign tx_sf_bits = ~carrier_on;
    assign tx_mos_select = dlctl_q[`DLC_DL_SIG_SELECT];

    // Transmit bit path with automatic and forced abort
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_prev_q <= 1'b0;
            abort_cnt_q <= 4'h0;
            abort_sh_q <= 8'h00;
            tx_dl_bit <= 1'b1;
            tx_abort_active <= 1'b0;
        end else if (tx_bit_en) begin
            sel_prev_q <= dlctl_q[`DLC_DL_SIG_SELECT];
            if (sel_prev_q && !dlctl_q[`DLC_DL_SIG_SELECT] && !dlctl_q[`DLC_DL_AUTO_ABORT_DIS] &&
                abort_cnt_q == 4'h0) begin
                // Message-to-bit switch: zero then seven ones
                tx_dl_bit <= 1'b0;
                abort_sh_q <= `DLC_ABORT_PATTERN; // Bit 7 goes out now, 6..0 follow
                abort_cnt_q <= `DLC_ABORT_BITS - 4'h1;
                tx_abort_active <= 1'b1;
            end else if (abort_cnt_q != 4'h0) begin
                tx_dl_bit <= abort_sh_q[6];
                abort_sh_q <= {abort_sh_q[6:0], 1'b1};
                abort_cnt_q <= abort_cnt_q - 4'h1;
                tx_abort_active <= 1'b1;
            end else if (dlctl_q[`DLC_DL_TX_ABORT]) begin
                tx_dl_bit <= 1'b1;
                tx_abort_active <= 1'b1;
            end else begin
                tx_dl_bit <= tx_msg_bit;
                tx_abort_active <= 1'b0;
            end
        end
    end

    // Receive frame checking and duplicate comparison
    assign rx_take = rx_byte_valid & ~pushing_q & (carrier_on | ~rx_carrier_msg);
    assign rx_byte_ready = ~pushing_q;
    assign fcs_ok = dlctl_q[`DLC_DL_RX_CHECK_DIS] | (fcs_q == `DLC_FCS_GOOD);
    assign dup_now = dlctl_q[`DLC_DL_RX_DUP_DISCARD] & match_q & (cur_len_q == ref_len_q);

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fcs_q <= `DLC_FCS_INIT;
            cur_len_q <= {(`DLC_RXBUF_AW+1){1'b0}};
            ref_len_q <= {(`DLC_RXBUF_AW+1){1'b0}};
            push_idx_q <= {(`DLC_RXBUF_AW+1){1'b0}};
            push_len_q <= {(`DLC_RXBUF_AW+1){1'b0}};
            match_q <= 1'b1;
            pushing_q <= 1'b0;
            fcs_err_q <= 1'b0;
            dup_q <= 1'b0;
            good_q <= 1'b0;
            frames_q <= 8'h00;
        end else begin
            if (rx_take && !rx_frame_end) begin
                fcs_q <= fcs_byte(fcs_q, rx_byte);
                if (cur_len_q != `DLC_RXBUF_DEPTH) begin
                    cur_len_q <= cur_len_q + 1'b1;
                    if (cur_len_q >= ref_len_q || ref_buf[cur_len_q[`DLC_RXBUF_AW-1:0]] != rx_byte) begin
                        match_q <= 1'b0;
                    end
                end
            end else if (rx_take && rx_frame_end) begin
                // Frame closed: accept, discard as duplicate, or drop on check failure
                fcs_q <= `DLC_FCS_INIT;
                cur_len_q <= {(`DLC_RXBUF_AW+1){1'b0}};
                match_q <= 1'b1;
                fcs_err_q <= ~fcs_ok;
                dup_q <= fcs_ok & dup_now;
                good_q <= fcs_ok & ~dup_now;
                if (fcs_ok && !dup_now) begin
                    ref_len_q <= cur_len_q;
                    push_len_q <= cur_len_q;
                    push_idx_q <= {(`DLC_RXBUF_AW+1){1'b0}};
                    pushing_q <= (cur_len_q != {(`DLC_RXBUF_AW+1){1'b0}});
                    frames_q <= frames_q + 8'h01;
                end
            end
            if (pushing_q && fifo_in_ready) begin
                push_idx_q <= push_idx_q + 1'b1;
                if (push_idx_q + 1'b1 == push_len_q) begin
                    pushing_q <= 1'b0;
                end
            end
        end
    end

    // Frame bytes in staging; accepted frame copied to reference store
    always @(posedge core_clk) begin
        if (rx_take && !rx_frame_end && cur_len_q != `DLC_RXBUF_DEPTH) begin
            cur_buf[cur_len_q[`DLC_RXBUF_AW-1:0]] <= rx_byte;
        end
        if (rx_take && rx_frame_end && fcs_ok && !dup_now) begin
            for (i = 0; i < `DLC_RXBUF_DEPTH; i = i + 1) begin
                ref_buf[i] <= cur_buf[i];
            end
        end
    end

    // Accepted frames drain through the FIFO
    dlc_fifo #(
        .WIDTH(8),
        .DEPTH(4),
        .AW(2)
    ) u_fifo (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(pushing_q),
        .in_ready(fifo_in_ready),
        .in_data(ref_buf[push_idx_q[`DLC_RXBUF_AW-1:0]]),
        .out_valid(rx_out_valid),
        .out_ready(rx_out_ready),
        .out_data(rx_out_data)
    );
endmodule

// ===== logic/dlc_defines.vh
// Register map, field positions, reset values and codes for the data-link control block
`ifndef DLC_DEFINES_VH
`define DLC_DEFINES_VH
// Register addresses
`define DLC_ADDR_W 8
`define DLC_ADDR_PRCTL 8'h00
`define DLC_ADDR_DLCTL 8'h01
`define DLC_ADDR_STAT 8'h02
`define DLC_ADDR_RXDATA 8'h03
// Reset values
`define DLC_PRCTL_RST 8'h00
`define DLC_DLCTL_RST 8'h00
// Field positions in the performance report control register
`define DLC_PR_FIRST_FLAG 7
`define DLC_PR_SECOND_FLAG 6
`define DLC_PR_SPARE_ONE 5
`define DLC_PR_SPARE_TWO 4
// Field positions in the data-link control register
`define DLC_DL_CARRIER_EN 7
`define DLC_DL_AUTO_ABORT_DIS 6
`define DLC_DL_RX_CHECK_DIS 5
`define DLC_DL_RX_DUP_DISCARD 4
`define DLC_DL_TX_ABORT 3
`define DLC_DL_SIG_SELECT 0
// Framing format codes
`define DLC_FMT_SF 2'h0
`define DLC_FMT_ESF 2'h1
`define DLC_FMT_CARRIER 2'h2
// Abort pattern: one zero then seven ones, sent MSB first
`define DLC_ABORT_PATTERN 8'h7F
`define DLC_ABORT_BITS 4'h8
// Frame check sequence residue and reflected generator
`define DLC_FCS_INIT 16'hFFFF
`define DLC_FCS_GOOD 16'hF0B8
`define DLC_FCS_POLY 16'h8408
// Receive buffer depth in bytes
`define DLC_RXBUF_DEPTH 16
`define DLC_RXBUF_AW 4
`endif

// ===== logic/dlc_fifo.v
// Parameterised valid/ready FIFO for received data bytes
`timescale 1ns/1ns
module dlc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    // Honest full and empty from the occupancy count
    assign in_ready = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage writes
    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and count
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// ===== testbench/dlc_control_props.sv
// Checker for the control register fields and transmit behaviour
`timescale 1ns/1ns
`include "dlc_defines.vh"
module dlc_control_props (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Register port
    input wire [`DLC_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Transmit side and received stream
    input wire [1:0] frame_format,
    input wire tx_bit_en,
    input wire tx_dl_bit,
    input wire tx_abort_active,
    input wire tx_mos_select,
    input wire tx_carrier_active,
    input wire tx_sf_bits,
    input wire [7:0] tx_network_performance_report_fields,
    input wire [7:0] tx_supplementary_performance_report_fields,
    input wire rx_out_valid,
    input wire rx_out_ready
);
    reg [7:0] pr_q;
    reg [7:0] dl_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Shadow copies of both control registers
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pr_q <= 8'h00;
            dl_q <= 8'h00;
        end else if (reg_wr && reg_addr == `DLC_ADDR_PRCTL) begin
            pr_q <= reg_wdata;
        end else if (reg_wr && reg_addr == `DLC_ADDR_DLCTL) begin
            dl_q <= reg_wdata;
        end
    end
    network_performance_report_fields_a: assert property (tx_network_performance_report_fields == {pr_q[7:6], 6'h00})
        else $error("network report fields differ from register");
    supplementary_performance_report_fields_a: assert property (tx_supplementary_performance_report_fields == {2'h0, pr_q[5:0]})
        else $error("supplementary report fields differ from register");
    carrier_gate_a: assert property (tx_carrier_active == (dl_q[7] &&
        (frame_format == `DLC_FMT_ESF || frame_format == `DLC_FMT_CARRIER))) else $error("carrier gating wrong");
    sf_bits_a: assert property (tx_sf_bits != tx_carrier_active)
        else $error("plain framing bits wrong");
    signal_select_a: assert property (tx_mos_select == dl_q[0])
        else $error("signalling select wrong");
    forced_abort_a: assert property (tx_bit_en && dl_q[3] |=> tx_dl_bit && tx_abort_active)
        else $error("forced abort not sent");
    no_auto_abort_a: assert property ($rose(tx_abort_active) |-> dl_q[3] || !dl_q[6])
        else $error("abort started while disabled");
    read_back_a: assert property (reg_rd && reg_addr < 8'h02 |=>
        reg_rdata == ($past(reg_addr) == 8'h00 ? pr_q : dl_q)) else $error("register read back wrong");
    cover property (tx_bit_en && dl_q[3]);
    cover property ($rose(tx_abort_active) && !dl_q[3]);
    cover property (rx_out_valid && rx_out_ready);
endmodule
bind dlc_control dlc_control_props chk_u (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .frame_format, .tx_bit_en, .tx_dl_bit, .tx_abort_active, .tx_mos_select, .tx_carrier_active,
    .tx_sf_bits, .tx_network_performance_report_fields, .tx_supplementary_performance_report_fields, .rx_out_valid, .rx_out_ready);

// ===== testbench/dlc_remote_model.sv
// Remote terminal model delivering received frames byte by byte
`timescale 1ns/1ns
module dlc_remote_model (
    // Clock
    input wire core_clk,
    // Frame bytes towards the block
    input wire rx_byte_ready,
    output reg rx_byte_valid = 1'b0,
    output reg [7:0] rx_byte = 8'hA5,
    output reg rx_frame_end = 1'b0,
    output reg rx_carrier_msg = 1'b0
);
    integer seed = 2723;
    // Bytes then the closing strobe, each held until rx_byte_ready is high, with idle gaps when slow
    task send(input integer n, input logic [39:0] d, input logic carr, input logic slow);
        integer i;
        for (i = 0; i <= n; i = i + 1) begin
            rx_byte_valid <= 1'b1;
            rx_frame_end <= (i == n);
            rx_byte <= (i == n) ? ~rx_byte : d[8*i +: 8];
            rx_carrier_msg <= carr;
            @(posedge core_clk);
            while (!rx_byte_ready) @(posedge core_clk);
            if (slow) begin
                rx_byte_valid <= 1'b0;
                rx_byte <= ~rx_byte;
                repeat (1 + {$random(seed)} % 3) @(posedge core_clk);
            end
        end
        rx_byte_valid <= 1'b0;
        rx_frame_end <= 1'b0;
        rx_byte <= ~rx_byte;
    endtask
endmodule

// ===== testbench/dlc_control_tb.sv
// Self-checking bench for the data-link control block
`timescale 1ns/1ns
`include "dlc_defines.vh"
module dlc_control_tb;
    reg core_clk = 0;
    reg reset_n = 0;
    reg [7:0] reg_addr = 0;
    reg [7:0] reg_wdata = 0;
    reg reg_wr = 0;
    reg reg_rd = 0;
    reg [1:0] frame_format = 0;
    reg tx_bit_en = 0;
    reg tx_msg_bit = 0;
    reg rx_out_ready = 0;
    reg rd_d = 0;
    wire [7:0] reg_rdata, rx_out_data, rx_byte;
    wire tx_dl_bit, rx_out_valid, rx_byte_valid, rx_frame_end, rx_carrier_msg, rx_byte_ready;
    integer seed = 2723, fails = 0, n_checks = 0, i, n, ones;
    logic [7:0] eq[$], mq[$], rxq[$];
    logic [39:0] fa, fb;
    always #2 core_clk = ~core_clk;
    dlc_control dut_u (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frame_format,
        .tx_bit_en, .tx_msg_bit, .tx_dl_bit, .tx_abort_active(), .tx_mos_select(), .tx_carrier_active(),
        .tx_sf_bits(), .tx_network_performance_report_fields(), .tx_supplementary_performance_report_fields(), .rx_byte_valid, .rx_byte, .rx_frame_end,
        .rx_carrier_msg, .rx_out_valid, .rx_out_ready, .rx_out_data, .rx_byte_ready);
    dlc_remote_model peer_u (.core_clk, .rx_byte_ready, .rx_byte_valid, .rx_byte, .rx_frame_end, .rx_carrier_msg);
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Three data bytes followed by their inverted check sequence, low byte first
    function [39:0] with_fcs(input [23:0] d);
        reg [15:0] c;
        integer k;
        begin
            c = `DLC_FCS_INIT;
            for (k = 0; k < 24; k = k + 1) c = (c[0] ^ d[k]) ? ((c >> 1) ^ `DLC_FCS_POLY) : (c >> 1);
            with_fcs = {~c, d};
        end
    endfunction
    task results;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One bus cycle; a read notes its expected masked data
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        if (!w) eq.push_back(d & m);
        if (!w) mq.push_back(m);
        @(posedge core_clk);
    endtask
    task idle(input integer k);
        reg_wr <= 0;
        reg_rd <= 0;
        repeat (k) @(posedge core_clk);
    endtask
    // Sends one five-byte frame and waits until it has been drained
    task frame(input logic [39:0] d, input logic c, input logic acc);
        idle(1);
        for (i = 0; acc && i < 5; i++) rxq.push_back(d[8*i +: 8]);
        peer_u.send(5, d, c, $random(seed));
        repeat (2) @(posedge core_clk);
        for (i = 0; i < 300 && (!rx_byte_ready || rxq.size() > 0); i++) @(posedge core_clk);
    endtask
    // Read data and drained bytes compared against the oldest notes
    always @(posedge core_clk) begin
        if (rd_d) chk(reg_rdata & mq.pop_front(), eq.pop_front());
        if (rx_out_valid && rx_out_ready) chk(rx_out_data, rxq.pop_front());
        rd_d <= reg_rd;
        rx_out_ready <= ({$random(seed)} % 3) != 0;
    end
    initial begin
        #100000;
        fails = fails + 1;
        results;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1;
        @(posedge core_clk);
        bus(0, `DLC_ADDR_PRCTL, 8'h00, 8'hFF);
        bus(0, `DLC_ADDR_DLCTL, 8'h00, 8'hFF);
        bus(0, 8'h07, 8'h00, 8'hFF);
        for (n = 0; n < 6; n++) begin
            fb = $random(seed);
            bus(1, `DLC_ADDR_PRCTL, fb[7:0], 0);
            bus(0, `DLC_ADDR_PRCTL, fb[7:0], 8'hFF);
        end
        // Every framing format with the carrier enable off and on
        for (n = 0; n < 8; n++) begin
            frame_format <= n[1:0];
            bus(1, `DLC_ADDR_DLCTL, {n[2], 7'h00}, 0);
            bus(0, `DLC_ADDR_DLCTL, {n[2], 7'h00}, 8'hFF);
        end
        frame_format <= `DLC_FMT_ESF;
        tx_bit_en <= 1;
        bus(1, `DLC_ADDR_DLCTL, 8'h08, 0);
        idle(3);
        repeat (8) @(posedge core_clk) chk(tx_dl_bit, 8'h01);
        bus(1, `DLC_ADDR_DLCTL, 8'h00, 0);
        idle(12);
        chk(tx_dl_bit, 8'h00);
        // Message-to-bit switch: one run of seven ones only when enabled
        for (n = 0; n < 2; n++) begin
            bus(1, `DLC_ADDR_DLCTL, {1'b0, n[0], 6'h01}, 0);
            idle(4);
            bus(1, `DLC_ADDR_DLCTL, {1'b0, n[0], 6'h00}, 0);
            idle(1);
            ones = 0;
            repeat (20) @(posedge core_clk) ones = ones + tx_dl_bit;
            chk(ones[7:0], n ? 8'h00 : 8'h07);
        end
        tx_bit_en <= 0;
        fa = {$random(seed), 8'h00};
        fb = {$random(seed), 8'h5A};
        bus(1, `DLC_ADDR_DLCTL, 8'h20, 0);
        frame(fa, 0, 1);
        bus(1, `DLC_ADDR_DLCTL, 8'h30, 0);
        frame(fa, 0, 0);
        frame(fb, 0, 1);
        bus(1, `DLC_ADDR_DLCTL, 8'h20, 0);
        frame(fb, 0, 1);
        bus(1, 8'h03, 8'hFF, 0);
        bus(0, 8'h03, 8'h03, 8'hFF);
        bus(1, `DLC_ADDR_DLCTL, 8'h00, 0);
        frame(fa, 0, 0);
        bus(0, 8'h02, 8'h02, 8'h02);
        bus(0, 8'h03, 8'h03, 8'hFF);
        fa = with_fcs(fb[31:8]);
        frame(fa, 0, 1);
        bus(0, 8'h02, 8'h08, 8'h0A);
        bus(1, `DLC_ADDR_DLCTL, 8'h20, 0);
        frame(fb, 1, 0);
        bus(1, `DLC_ADDR_DLCTL, 8'hA0, 0);
        frame(fb, 1, 1);
        bus(0, 8'h03, 8'h05, 8'hFF);
        idle(3);
        chk(rxq.size(), 8'h00);
        results;
    end
endmodule
